/* design/smc_pkg.sv */
package smc_pkg;

   // register map, word offsets on the plain register port
   localparam logic [3:0] OFF_SOFT_REQ    = 4'h0;
   localparam logic [3:0] OFF_ERR_SUMMARY = 4'h1;
   localparam logic [3:0] OFF_LEVEL       = 4'h2;
   localparam logic [3:0] OFF_STATUS      = 4'h3;
   localparam logic [3:0] OFF_OP          = 4'h4;
   localparam logic [3:0] OFF_CHECK_INFO  = 4'h5;

   // soft interrupt request fields
   localparam int SIR_ASYNC_BIT = 0;
   localparam int SIR_DEFER_BIT = 1;

   // error summary fields
   localparam int ES_UNCORR_BIT  = 0;
   localparam int ES_SYS_CE_BIT  = 1;
   localparam int ES_PROC_CE_BIT = 2;
   localparam int ES_PROC_DIS    = 3;
   localparam int ES_SYS_DIS     = 4;
   localparam int ES_MASK_ALL    = 5;

   // status register fields
   localparam int ST_IE_BIT    = 0;
   localparam int ST_CATA_BIT  = 1;
   localparam int ST_PEND_BIT  = 2;

   // operation register: opcode in [3:0], operand in [10:8]
   localparam int OP_ARG_LSB = 8;

   // reset values
   localparam logic [1:0] SOFT_REQ_RST = 2'h0;
   localparam logic [5:0] ERR_SUM_RST  = 6'h18;
   localparam logic [2:0] LEVEL_RST    = 3'h7;

   typedef enum logic [3:0] {
      SMC_OP_NONE     = 4'b0000,
      SMC_OP_SWAP_LVL = 4'b0001,
      SMC_OP_DISABLE  = 4'b0010,
      SMC_OP_ENABLE   = 4'b0011,
      SMC_OP_SET_REQ  = 4'b0100,
      SMC_OP_CLR_REQ  = 4'b0101
   } smc_op_type;

   // machine check type codes
   typedef enum logic [1:0] {
      SMC_MC_UNC_NORETRY = 2'b00,
      SMC_MC_CORR        = 2'b01,
      SMC_MC_UNC_RETRY   = 2'b10,
      SMC_MC_RSVD        = 2'b11
   } smc_mc_type;

   // error event inputs, one-cycle pulses
   typedef struct packed {
      logic proc_ce;
      logic sys_ce;
      logic uncorr;
      logic retry;
      logic pin_err;
   } smc_err_in_type;

   typedef struct packed {
      logic [1:0]  soft_req;
      logic [5:0]  err_sum;
      logic [2:0]  level;
      logic        glob_en;
      logic        catastrophic;
      logic        ack_off;
      logic        logout;
      logic        restart_chk;
      logic        mc_raise;
      smc_mc_type  mc_type;
      logic        pin_irq;
      logic        soft_ack;
      logic [31:0] rdata;
   } smc_state_type;

endpackage : smc_pkg

/* design/smc_ctl.sv */
// The placing of the registers and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ns
// How it works
// RQ1: swap-level op loads new level from operand, returns the old one.
// RQ2: disable-all op clears global enable, level unchanged.
// RQ3: enable-all op sets global enable, level unchanged, level still filters soft requests; hardware interrupts are not filtered by level.
// RQ4: one global enable bit gates the hardware and soft interrupt sources; pin error interrupts bypass it.
// RQ5: soft request bit 1 is the deferred-call pending flag, read/write.
// RQ6: soft request bit 0 is the async-call pending flag, read/write.
// RQ7: set-request op raises selected soft request bits only.
// RQ8: clear-request op drops selected soft request bits only.
// RQ9: internal soft interrupts acknowledged here; system interrupts elsewhere.
// RQ10: pin-level errors go out as ordinary interrupts, never machine checks.
// RQ11: all-checks mask suppresses every machine check.
// RQ12: system correctable disable suppresses system correctable reports.
// RQ13: processor correctable disable suppresses processor correctable reports.
// RQ14: processor correctable flag records a reported processor error.
// RQ15: system correctable flag records a reported system error.
// RQ16: uncorrectable flag records an uncorrectable check in progress.
// RQ17: type code 00 uncorrectable no retry, 01 correctable, 10 retry.
// RQ18: check arriving with uncorrectable flag set is catastrophic.
// RQ19: check taken while firmware layer runs is catastrophic.
// RQ20: catastrophic stops further acks, emits logout, then restart check.
// RQ21: software keeps correctable reporting off during init, then enables.
// RQ22: uncorrectable errors raise a machine check immediately.
// RQ23: soft request bits 31..2 read zero, writes ignored.
// RQ24: summary bits 0..5: uncorr, sys ce, proc ce, proc dis, sys dis, mask.
module smc_ctl
   import smc_pkg::*;
(
   input  wire logic           core_clk_i,
   input  wire logic           sys_rst_i,
   input  wire logic [3:0]     reg_addr_i,
   input  wire logic [31:0]    reg_wdata_i,
   input  wire logic           reg_wr_i,
   input  wire logic           reg_rd_i,
   output logic      [31:0]    reg_rdata_o,
   input  wire smc_err_in_type err_i,
   input  wire logic           fw_active_i,
   input  wire logic [7:0]     hw_irq_i,
   output logic                irq_o,
   output logic                soft_ack_o,
   output logic                pin_irq_o,
   output logic                mc_raise_o,
   output logic      [1:0]     mc_type_o,
   output logic                logout_o,
   output logic                restart_chk_o,
   output logic                catastrophic_o
);

   smc_state_type st_r;
   smc_state_type st_nxt;
   logic          irq_r;

   // pending soft requests above the current level; deferred is level 2, async level 1
   function automatic logic soft_above(input logic [1:0] req, input logic [2:0] lvl);
      soft_above = (req[SIR_DEFER_BIT] && lvl < 3'h2) || (req[SIR_ASYNC_BIT] && lvl < 3'h1);
   endfunction : soft_above

   // next-state logic: register writes, ops, then hardware events so a set beats a clear
   always_comb begin
      logic       wr_op;
      logic [2:0] arg;
      logic       mc_ev;
      logic       ce_ok_p;
      logic       ce_ok_s;
      logic       unc_ok;
      // every local gets a value first, so none is ever held over as a latch
      unc_ok  = 1'b0;
      ce_ok_p = 1'b0;
      ce_ok_s = 1'b0;
      mc_ev   = 1'b0;
      wr_op   = reg_wr_i && (reg_addr_i == OFF_OP);
      arg     = reg_wdata_i[OP_ARG_LSB +: 3];
      st_nxt  = st_r;
      st_nxt.rdata       = 32'h0000_0000;
      st_nxt.mc_raise    = 1'b0;
      st_nxt.logout      = 1'b0;
      st_nxt.restart_chk = st_r.logout;                              // RQ20
      st_nxt.soft_ack    = 1'b0;
      st_nxt.pin_irq     = err_i.pin_err;                            // RQ10

      // plain register writes
      if (reg_wr_i) begin
         unique case (reg_addr_i)
            OFF_SOFT_REQ:    st_nxt.soft_req = reg_wdata_i[1:0];   // RQ5 RQ6 RQ23
            OFF_ERR_SUMMARY: st_nxt.err_sum  = reg_wdata_i[5:0];   // RQ24
            OFF_LEVEL:       st_nxt.level    = reg_wdata_i[2:0];
            OFF_STATUS: begin
               st_nxt.glob_en = reg_wdata_i[ST_IE_BIT];
               // writing 1 re-arms after firmware recovery
               if (reg_wdata_i[ST_CATA_BIT]) begin
                  st_nxt.catastrophic = 1'b0;
                  st_nxt.ack_off      = 1'b0;
               end
            end
            default: ;
         endcase
      end

      // operation port
      if (wr_op) begin
         unique case (smc_op_type'(reg_wdata_i[3:0]))
            SMC_OP_SWAP_LVL: st_nxt.level   = arg;                   // RQ1
            SMC_OP_DISABLE:  st_nxt.glob_en = 1'b0;                  // RQ2 RQ4
            SMC_OP_ENABLE:   st_nxt.glob_en = 1'b1;                  // RQ3 RQ4
            SMC_OP_SET_REQ:  st_nxt.soft_req = st_r.soft_req | arg[1:0];   // RQ7
            SMC_OP_CLR_REQ:  st_nxt.soft_req = st_r.soft_req & ~arg[1:0];  // RQ8
            default: ;
         endcase
      end

      // machine check gating
      unc_ok  = err_i.uncorr && !st_r.err_sum[ES_MASK_ALL];                          // RQ11
      ce_ok_p = err_i.proc_ce && !st_r.err_sum[ES_MASK_ALL]
                && !st_r.err_sum[ES_PROC_DIS];                                        // RQ11 RQ13
      ce_ok_s = err_i.sys_ce && !st_r.err_sum[ES_MASK_ALL]
                && !st_r.err_sum[ES_SYS_DIS];                                         // RQ11 RQ12
      mc_ev   = (unc_ok || ce_ok_p || ce_ok_s) && !st_r.ack_off;                     // RQ20

      if (mc_ev) begin
         if (st_r.err_sum[ES_UNCORR_BIT] || fw_active_i) begin    // RQ18 RQ19
            // nested or firmware-time check: no dispatch, stop acks, log out
            st_nxt.catastrophic = 1'b1;
            st_nxt.ack_off      = 1'b1;                            // RQ20
            st_nxt.logout       = 1'b1;                            // RQ20
         end else begin
            st_nxt.mc_raise = 1'b1;                                // RQ22
            if (unc_ok) begin
               st_nxt.err_sum[ES_UNCORR_BIT] = 1'b1;               // RQ16
               st_nxt.mc_type = err_i.retry ? SMC_MC_UNC_RETRY : SMC_MC_UNC_NORETRY; // RQ17
            end else begin
               st_nxt.mc_type = SMC_MC_CORR;                       // RQ17
            end
            if (ce_ok_p) st_nxt.err_sum[ES_PROC_CE_BIT] = 1'b1;   // RQ14
            if (ce_ok_s) st_nxt.err_sum[ES_SYS_CE_BIT]  = 1'b1;   // RQ15
         end
      end

      // soft interrupt taken: acknowledged locally, system ones are not
      if (st_r.glob_en && soft_above(st_r.soft_req, st_r.level)
          && (hw_irq_i == 8'h00)) begin
         st_nxt.soft_ack = 1'b1;                                   // RQ9
      end

      // read data, one cycle after the strobe
      if (reg_rd_i) begin
         unique case (reg_addr_i)
            OFF_SOFT_REQ:    st_nxt.rdata = {30'h0, st_r.soft_req};   // RQ23
            OFF_ERR_SUMMARY: st_nxt.rdata = {26'h0, st_r.err_sum};
            OFF_LEVEL:       st_nxt.rdata = {29'h0, st_r.level};
            OFF_STATUS:      st_nxt.rdata = {29'h0, irq_r, st_r.catastrophic, st_r.glob_en};
            OFF_OP:          st_nxt.rdata = {29'h0, st_r.level};       // RQ1
            OFF_CHECK_INFO:  st_nxt.rdata = {30'h0, st_r.mc_type};
            default:         st_nxt.rdata = 32'h0000_0000;
         endcase
      end
      // a swap returns the level in force before it
      if (wr_op && smc_op_type'(reg_wdata_i[3:0]) == SMC_OP_SWAP_LVL) begin
         st_nxt.rdata = {29'h0, st_r.level};                        // RQ1
      end
   end

   // single state register
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         st_r          <= '0;
         st_r.soft_req <= SOFT_REQ_RST;
         st_r.err_sum  <= ERR_SUM_RST;     // correctable reporting off until enabled
         st_r.level    <= LEVEL_RST;
         irq_r         <= 1'b0;
      end else begin
         st_r  <= st_nxt;
         // interrupt line: hardware or soft above level, gated by the one enable
         irq_r <= st_nxt.glob_en && ((hw_irq_i != 8'h00)
                  || soft_above(st_nxt.soft_req, st_nxt.level));   // RQ4 RQ3
      end
   end

   assign reg_rdata_o    = st_r.rdata;
   assign irq_o          = irq_r;
   assign soft_ack_o     = st_r.soft_ack;
   assign pin_irq_o      = st_r.pin_irq;
   assign mc_raise_o     = st_r.mc_raise;
   assign mc_type_o      = st_r.mc_type;
   assign logout_o       = st_r.logout;
   assign restart_chk_o  = st_r.restart_chk;
   assign catastrophic_o = st_r.catastrophic;

endmodule : smc_ctl

/* tb/smc_asserts.sv */
`timescale 1ns/1ns
module smc_asserts
   import smc_pkg::*;
(
   input wire logic           core_clk_i,
   input wire logic           sys_rst_i,
   input wire logic [3:0]     reg_addr_i,
   input wire logic           reg_wr_i,
   input wire logic           reg_rd_i,
   input wire logic [31:0]    reg_rdata_o,
   input wire smc_err_in_type err_i,
   input wire logic           pin_irq_o,
   input wire logic           mc_raise_o,
   input wire logic [1:0]     mc_type_o,
   input wire logic           logout_o,
   input wire logic           restart_chk_o,
   input wire logic           catastrophic_o
);
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (sys_rst_i);
   // read data only ever follows a read or a level swap
   a_rdata_cause: assert property (reg_rdata_o != 32'h0 |->
      $past(reg_rd_i) || $past(reg_wr_i && reg_addr_i == OFF_OP)) else $error("stray read data");
   a_pin_route: assert property (err_i == 5'h01 |=> pin_irq_o && !mc_raise_o)
      else $error("pin error not routed as interrupt");
   a_pin_cause: assert property (pin_irq_o |-> $past(err_i.pin_err))
      else $error("pin interrupt without pin error");
   a_mc_cause: assert property (mc_raise_o |->
      $past(err_i.proc_ce || err_i.sys_ce || err_i.uncorr)) else $error("check without error");
   a_unc_type: assert property (mc_raise_o && $past(err_i.uncorr) |-> mc_type_o ==
      ($past(err_i.retry) ? SMC_MC_UNC_RETRY : SMC_MC_UNC_NORETRY)) else $error("bad check type");
   a_restart_after: assert property (logout_o |=> restart_chk_o && !logout_o)
      else $error("restart check not after logout");
   a_cata_logout: assert property ($rose(catastrophic_o) |-> ##[0:2] logout_o)
      else $error("catastrophic without logout");
   // once acks are off, a standing catastrophic state never logs out again
   a_acks_off: assert property ($past(catastrophic_o, 2) && catastrophic_o |-> !logout_o)
      else $error("logout while acks off");
endmodule : smc_asserts

bind smc_ctl smc_asserts i_smc_asserts (.core_clk_i, .sys_rst_i, .reg_addr_i, .reg_wr_i,
   .reg_rd_i, .reg_rdata_o, .err_i, .pin_irq_o, .mc_raise_o, .mc_type_o, .logout_o,
   .restart_chk_o, .catastrophic_o);

/* tb/tb_smc_ctl.sv */
`timescale 1ns/1ns
module tb_smc_ctl
   import smc_pkg::*;
;
   logic           core_clk_i = 1'b0, sys_rst_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
   logic           fw_active_i = 1'b0, irq_o, soft_ack_o, pin_irq_o, mc_raise_o;
   logic           logout_o, restart_chk_o, catastrophic_o;
   logic [3:0]     reg_addr_i = 4'h0;
   logic [31:0]    reg_wdata_i = 32'h0, reg_rdata_o;
   logic [7:0]     hw_irq_i = 8'h0;
   logic [1:0]     mc_type_o;
   smc_err_in_type err_i = '0;
   int             errors = 0, compares = 0, cycles = 0, acks = 0;
   int             mcs = 0, logs = 0, rsts = 0, pins = 0;
   smc_ctl i_smc_ctl (.core_clk_i, .sys_rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
      .reg_rdata_o, .err_i, .fw_active_i, .hw_irq_i, .irq_o, .soft_ack_o, .pin_irq_o,
      .mc_raise_o, .mc_type_o, .logout_o, .restart_chk_o, .catastrophic_o);
   always #5 core_clk_i = ~core_clk_i;
   // hang guard; soft acks stay high while a soft request pends above the level, so they and the other outputs are counted per cycle rather than sampled
   always @(posedge core_clk_i) begin
      cycles++;
      if (soft_ack_o === 1'b1) acks++;
      if (mc_raise_o === 1'b1) mcs++;
      if (logout_o === 1'b1) logs++;
      if (restart_chk_o === 1'b1) rsts++;
      if (pin_irq_o === 1'b1) pins++;
      if (cycles == 3000) begin
         errors++;
         end_of_test();
      end
   end
   task automatic end_of_test();
      if (errors == 0 && compares > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : end_of_test
   task automatic cmp(string name, logic [31:0] exp, logic [31:0] got);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("wrong value %s expected %h seen %h", name, exp, got);
      end
   endtask : cmp
   task automatic wr(logic [3:0] a, logic [31:0] d);
      @(posedge core_clk_i);
      reg_wr_i <= 1'b1;
      reg_addr_i <= a;
      reg_wdata_i <= d;
      @(posedge core_clk_i);
      reg_wr_i <= 1'b0;
   endtask : wr
   // data stand only in the cycle after the strobe, so look just past that edge
   task automatic rd(logic [3:0] a, logic [31:0] exp);
      @(posedge core_clk_i);
      reg_rd_i <= 1'b1;
      reg_addr_i <= a;
      @(posedge core_clk_i);
      reg_rd_i <= 1'b0;
      #1 cmp("register read", exp, reg_rdata_o);
   endtask : rd
   task automatic op(smc_op_type c, logic [2:0] arg);
      wr(OFF_OP, (32'(arg) << OP_ARG_LSB) | 32'(c));
   endtask : op
   task automatic ep(logic [4:0] v);
      @(posedge core_clk_i);
      err_i <= v;
      @(posedge core_clk_i);
      err_i <= '0;
      repeat (3) @(posedge core_clk_i);
   endtask : ep
   initial begin
      repeat (16) @(posedge core_clk_i);
      sys_rst_i <= 1'b0;
      rd(OFF_SOFT_REQ, 32'h0);
      rd(OFF_ERR_SUMMARY, 32'h18);
      rd(OFF_LEVEL, 32'h7);
      rd(OFF_STATUS, 32'h0);
      rd(4'hF, 32'h0);
      wr(OFF_SOFT_REQ, 32'hFFFFFFFF);
      rd(OFF_SOFT_REQ, 32'h3);
      wr(OFF_SOFT_REQ, 32'h0);
      op(SMC_OP_SET_REQ, 3'h2);
      rd(OFF_SOFT_REQ, 32'h2);
      op(SMC_OP_SET_REQ, 3'h1);
      rd(OFF_SOFT_REQ, 32'h3);
      op(SMC_OP_CLR_REQ, 3'h2);
      rd(OFF_SOFT_REQ, 32'h1);
      op(SMC_OP_CLR_REQ, 3'h1);
      rd(OFF_SOFT_REQ, 32'h0);
      op(SMC_OP_SWAP_LVL, 3'h0);
      #1 cmp("old level", 32'h7, reg_rdata_o);
      rd(OFF_LEVEL, 32'h0);
      op(SMC_OP_SET_REQ, 3'h1);
      op(SMC_OP_ENABLE, 3'h0);
      repeat (4) @(posedge core_clk_i);
      cmp("soft ack seen", 32'h1, 32'(acks > 0));
      op(SMC_OP_CLR_REQ, 3'h1);
      hw_irq_i <= 8'h01;
      repeat (3) @(posedge core_clk_i);
      #1 cmp("irq_o", 32'h1, 32'(irq_o));
      op(SMC_OP_DISABLE, 3'h0);
      repeat (2) @(posedge core_clk_i);
      #1 cmp("irq_o", 32'h0, 32'(irq_o));
      rd(OFF_LEVEL, 32'h0);
      op(SMC_OP_ENABLE, 3'h0);
      rd(OFF_STATUS, 32'h5);
      rd(OFF_LEVEL, 32'h0);
      op(SMC_OP_DISABLE, 3'h0);
      hw_irq_i <= 8'h00;
      // correctable reporting is off out of reset and is switched on here
      wr(OFF_ERR_SUMMARY, 32'h0);
      ep(5'h10);
      rd(OFF_ERR_SUMMARY, 32'h4);
      rd(OFF_CHECK_INFO, 32'h1);
      ep(5'h08);
      rd(OFF_ERR_SUMMARY, 32'h6);
      wr(OFF_ERR_SUMMARY, 32'h18);
      ep(5'h10);
      ep(5'h08);
      rd(OFF_ERR_SUMMARY, 32'h18);
      wr(OFF_ERR_SUMMARY, 32'h20);
      ep(5'h04);
      rd(OFF_ERR_SUMMARY, 32'h20);
      ep(5'h01);
      rd(OFF_ERR_SUMMARY, 32'h20);
      wr(OFF_ERR_SUMMARY, 32'h0);
      ep(5'h04);
      rd(OFF_ERR_SUMMARY, 32'h1);
      rd(OFF_CHECK_INFO, 32'h0);
      wr(OFF_ERR_SUMMARY, 32'h0);
      ep(5'h06);
      rd(OFF_CHECK_INFO, 32'h2);
      ep(5'h04);
      rd(OFF_STATUS, 32'h2);
      ep(5'h04);
      wr(OFF_STATUS, 32'h2);
      rd(OFF_STATUS, 32'h0);
      wr(OFF_ERR_SUMMARY, 32'h0);
      fw_active_i <= 1'b1;
      ep(5'h10);
      rd(OFF_STATUS, 32'h2);
      cmp("machine checks raised", 32'h4, 32'(mcs));
      cmp("logout pulses", 32'h2, 32'(logs));
      cmp("restart checks", 32'h2, 32'(rsts));
      cmp("pin interrupts", 32'h1, 32'(pins));
      end_of_test();
   end
endmodule : tb_smc_ctl
